//--- pmc_map.vh
// Constants for the physical memory protection checker
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ********************************************************************
// Geometry
// ********************************************************************
`define PMC_NENT        16
`define PMC_GRAIN       0
`define PMC_AW          8

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define PMC_CFG_BASE    8'h00
`define PMC_ADDR_BASE   8'h40
`define PMC_STAT_OFF    8'h80

// ********************************************************************
// Configuration byte fields
// ********************************************************************
`define PMC_F_R         0
`define PMC_F_W         1
`define PMC_F_X         2
`define PMC_F_A_LO      3
`define PMC_F_A_HI      4
`define PMC_F_L         7

// ********************************************************************
// Match modes, access types, privilege levels
// ********************************************************************
`define PMC_A_OFF       2'h0
`define PMC_TOP_OF_RANGE_MODE        2'h1
`define PMC_FOUR_BYTE_REGION_MODE    2'h2
`define PMC_POWER_OF_TWO_REGION_MODE 2'h3
`define PMC_T_FETCH     2'h0
`define PMC_T_LOAD      2'h1
`define PMC_T_STORE     2'h2
`define PMC_P_USER      2'h0
`define PMC_P_SUPER     2'h1
`define PMC_P_MACHINE   2'h3

// ********************************************************************
// Reset values
// ********************************************************************
`define PMC_CFG_RST     8'h00
`define PMC_ADDR_RST    32'h00000000
`define PMC_CNT_RST     16'h0000

`endif

//--- pmc_entry.v
// One protection entry: region bounds and any-byte / all-byte match
`timescale 1ns/1ns
`include "pmc_map.vh"

module pmc_entry (
  input  wire [7:0]  cfg,
  input  wire [31:0] own_view,
  input  wire [31:0] prev_addr,
  input  wire [33:0] lo_w,
  input  wire [33:0] hi_w,
  output reg         hit_any,
  output reg         hit_full
);

  reg [31:0] prev_m;
  reg [32:0] nmask;
  reg [33:0] base;
  reg [33:0] top;
  reg        on;
  integer    k;

  always @* begin
    prev_m = prev_addr;
    nmask  = 33'h000000000;
    base   = 34'h000000000;
    top    = 34'h000000000;
    on     = 1'b0;
    // Grain bits of the lower bound play no part in the range
    for (k = 0; k < 32; k = k + 1) begin
      if (k < `PMC_GRAIN)
        prev_m[k] = 1'b0;
    end
    case (cfg[`PMC_F_A_HI:`PMC_F_A_LO])
      `PMC_TOP_OF_RANGE_MODE: begin
        on   = 1'b1;
        base = {2'b00, prev_m};
        top  = {2'b00, own_view};
      end
      `PMC_FOUR_BYTE_REGION_MODE: begin
        on   = 1'b1;
        base = {2'b00, own_view};
        top  = base + 34'h000000001;
      end
      `PMC_POWER_OF_TWO_REGION_MODE: begin
        on    = 1'b1;
        nmask = {1'b0, own_view} ^ ({1'b0, own_view} + 33'h000000001);
        base  = {1'b0, {1'b0, own_view} & ~nmask};
        top   = base + {1'b0, nmask} + 34'h000000001;
      end
      default: begin
        on = 1'b0;
      end
    endcase
    hit_any  = on && (lo_w < top) && (hi_w >= base);
    hit_full = on && (lo_w >= base) && (hi_w < top);
  end

endmodule // pmc_entry

//--- pmc_top.v
// Physical memory protection checker with register port
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "pmc_map.vh"

module pmc_top (
  input  wire        clk,
  input  wire        rstn,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_we,
  input  wire        reg_re,
  output reg  [31:0] reg_rdata_r,
  input  wire        chk_valid,
  input  wire [33:0] chk_addr,
  input  wire [1:0]  chk_size,
  input  wire [1:0]  chk_type,
  input  wire [1:0]  chk_priv,
  input  wire        chk_ptw,
  output reg         res_valid_r,
  output reg         res_fail_r,
  output reg         exc_fetch_r,
  output reg         exc_load_r,
  output reg         exc_store_r
);

  // ******************************************************************
  // Helper functions
  // ******************************************************************

  // Entry index when the address hits a 16-word bank, else 5'h10
  function [4:0] pmc_bank_idx;
    input [7:0] a;
    input [7:0] bank;
    begin
      if (a[1:0] == 2'b00 && a[7:6] == bank[7:6])
        pmc_bank_idx = {1'b0, a[5:2]};
      else
        pmc_bank_idx = 5'h10;
    end
  endfunction

  // Value seen on read and used for matching
  function [31:0] pmc_view;
    input [31:0] a;
    input [7:0]  c;
    integer      k;
    begin
      pmc_view = a;
      // Stored word untouched; only this view is forced
      // grain read view
      for (k = 0; k < 32; k = k + 1) begin
        if (c[`PMC_F_A_HI] && (k < `PMC_GRAIN - 1))
          pmc_view[k] = 1'b1;
        if (!c[`PMC_F_A_HI] && (k < `PMC_GRAIN))
          pmc_view[k] = 1'b0;
      end
    end
  endfunction

  // Legalise a configuration byte on write
  function [7:0] pmc_legal_cfg;
    input [7:0] c;
    begin
      pmc_legal_cfg = {c[7], 2'b00, c[4:0]};
      if (!c[`PMC_F_R])
        pmc_legal_cfg[`PMC_F_W] = 1'b0;
      if ((`PMC_GRAIN >= 1) &&
          c[`PMC_F_A_HI:`PMC_F_A_LO] == `PMC_FOUR_BYTE_REGION_MODE)
        pmc_legal_cfg[`PMC_F_A_HI:`PMC_F_A_LO] = `PMC_A_OFF;
    end
  endfunction

  // True when the entry's mode is top-of-range
  function pmc_is_top_range;
    input [7:0] c;
    begin
      pmc_is_top_range = (c[`PMC_F_A_HI:`PMC_F_A_LO]
                          == `PMC_TOP_OF_RANGE_MODE);
    end
  endfunction

  // ******************************************************************
  // Entry state
  // ******************************************************************
  // sixteen entries
  // Lock bits live in the stored bytes and clear only on reset
  reg  [7:0]  cfg_r  [0:`PMC_NENT-1];
  reg  [31:0] addr_r [0:`PMC_NENT-1];
  reg  [15:0] fail_cnt_r;
  reg  [4:0]  last_ent_r;

  // Misaligned or unmapped offsets decode to 5'h10 and are ignored
  wire [4:0]  cfg_idx  = pmc_bank_idx(reg_addr, `PMC_CFG_BASE);
  wire [4:0]  addr_idx = pmc_bank_idx(reg_addr, `PMC_ADDR_BASE);

  wire [`PMC_NENT-1:0] ent_locked;
  wire [`PMC_NENT-1:0] addr_locked;
  wire [`PMC_NENT-1:0] hit_any;
  wire [`PMC_NENT-1:0] hit_full;
  wire [31:0]          view [0:`PMC_NENT-1];

  // ******************************************************************
  // Access range in words
  // ******************************************************************
  // word granular bounds
  // Last byte of the piece; a piece must not wrap the address top
  wire [34:0] hi_byte = {1'b0, chk_addr}
                      + (35'h000000001 << chk_size) - 35'h000000001;
  wire [33:0] lo_w = {2'b00, chk_addr[33:2]};
  wire [33:0] hi_w = {1'b0, hi_byte[34:2]};

  genvar gi;
  generate
    for (gi = 0; gi < `PMC_NENT; gi = gi + 1) begin : g_ent
      assign ent_locked[gi] = cfg_r[gi][`PMC_F_L];
      assign view[gi]       = pmc_view(addr_r[gi], cfg_r[gi]);

      if (gi == `PMC_NENT - 1) begin : g_last
        assign addr_locked[gi] = ent_locked[gi];
      end else begin : g_mid
        assign addr_locked[gi] = ent_locked[gi]
          | (ent_locked[gi+1] && pmc_is_top_range(cfg_r[gi+1]));
      end

      if (gi == 0) begin : g_first
        pmc_entry u_ent (
          .cfg       (cfg_r[gi]),
          .own_view  (view[gi]),
          .prev_addr (32'h00000000),
          .lo_w      (lo_w),
          .hi_w      (hi_w),
          .hit_any   (hit_any[gi]),
          .hit_full  (hit_full[gi])
        );
      end else begin : g_rest
        pmc_entry u_ent (
          .cfg       (cfg_r[gi]),
          .own_view  (view[gi]),
          .prev_addr (addr_r[gi-1]),
          .lo_w      (lo_w),
          .hi_w      (hi_w),
          .hit_any   (hit_any[gi]),
          .hit_full  (hit_full[gi])
        );
      end

      // **************************************************************
      // Register writes
      // **************************************************************
      // Write lands next cycle; a check in the write cycle sees old settings
      always @(posedge clk) begin
        if (!rstn) begin
          cfg_r[gi]  <= `PMC_CFG_RST;
          addr_r[gi] <= `PMC_ADDR_RST;
        end else if (reg_we) begin
          if (cfg_idx == gi && !ent_locked[gi])
            cfg_r[gi] <= pmc_legal_cfg(reg_wdata[7:0]);
          if (addr_idx == gi && !addr_locked[gi])
            addr_r[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ******************************************************************
  // Priority resolve and permission
  // ******************************************************************
  reg        dec_hit;
  reg        dec_full;
  reg  [4:0] dec_idx;
  reg  [7:0] dec_cfg;
  reg        perm_ok;
  reg        pass;
  reg  [1:0] eff_priv;
  integer    j;

  always @* begin
    dec_hit  = 1'b0;
    dec_full = 1'b0;
    dec_idx  = 5'h10;
    dec_cfg  = 8'h00;
    eff_priv = chk_ptw ? `PMC_P_SUPER : chk_priv;
    for (j = `PMC_NENT - 1; j >= 0; j = j - 1) begin
      if (hit_any[j]) begin
        dec_hit  = 1'b1;
        dec_full = hit_full[j];
        dec_idx  = j[4:0];
        dec_cfg  = cfg_r[j];
      end
    end
    case (chk_type)
      `PMC_T_FETCH: perm_ok = dec_cfg[`PMC_F_X];
      `PMC_T_LOAD:  perm_ok = dec_cfg[`PMC_F_R];
      `PMC_T_STORE: perm_ok = dec_cfg[`PMC_F_W];
      default:      perm_ok = 1'b0;
    endcase
    if (!dec_hit) begin
      pass = (eff_priv == `PMC_P_MACHINE);
    end else if (!dec_full) begin
      pass = 1'b0;
    end else if (eff_priv == `PMC_P_MACHINE && !dec_cfg[`PMC_F_L]) begin
      pass = 1'b1;
    end else begin
      pass = perm_ok;
    end
  end

  // ******************************************************************
  // Result and exception outputs
  // ******************************************************************
  // Each request is one piece; the pipeline merges pieces of an
  // instruction, so earlier passing pieces may already have landed.
  wire fail_nxt = chk_valid && !pass;

  always @(posedge clk) begin
    if (!rstn) begin
      res_valid_r <= 1'b0;
      res_fail_r  <= 1'b0;
      exc_fetch_r <= 1'b0;
      exc_load_r  <= 1'b0;
      exc_store_r <= 1'b0;
    end else begin
      res_valid_r <= chk_valid;
      res_fail_r  <= fail_nxt;
      exc_fetch_r <= fail_nxt && chk_type == `PMC_T_FETCH;
      exc_load_r  <= fail_nxt && chk_type == `PMC_T_LOAD;
      exc_store_r <= fail_nxt && chk_type == `PMC_T_STORE;
    end
  end

  // ******************************************************************
  // Status: fault count and deciding entry of last check
  // ******************************************************************
  wire        stat_sel = (reg_addr == `PMC_STAT_OFF);
  reg  [15:0] fail_cnt_nxt;
  reg  [4:0]  last_ent_nxt;

  // Saturate rather than wrap so a fault flood never reads as few
  always @* begin
    fail_cnt_nxt = fail_cnt_r;
    last_ent_nxt = last_ent_r;
    if (chk_valid) begin
      last_ent_nxt = dec_idx;
    end
    // A new fault wins over a software clear
    if (fail_nxt) begin
      if (fail_cnt_r != 16'hFFFF) begin
        fail_cnt_nxt = fail_cnt_r + 16'h0001;
      end
    end else if (reg_we && stat_sel) begin
      fail_cnt_nxt = `PMC_CNT_RST;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      fail_cnt_r <= `PMC_CNT_RST;
      last_ent_r <= 5'h10;
    end else begin
      fail_cnt_r <= fail_cnt_nxt;
      last_ent_r <= last_ent_nxt;
    end
  end

  // ******************************************************************
  // Read port
  // ******************************************************************
  reg  [31:0] rdata_nxt;

  // Zero outside the read-data cycle so no stale word lingers
  always @* begin
    rdata_nxt = 32'h00000000;
    if (reg_re) begin
      if (cfg_idx != 5'h10) begin
        rdata_nxt = {24'h000000, cfg_r[cfg_idx[3:0]]};
      end else if (addr_idx != 5'h10) begin
        rdata_nxt = view[addr_idx[3:0]];
      end else if (stat_sel) begin
        rdata_nxt = {fail_cnt_r, 11'h000, last_ent_r};
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_r <= 32'h00000000;
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // checked at access time
  // Translation happens upstream; each request is checked when it
  // arrives, so stale settings come only from a cached translation or from a check in a register write cycle.

endmodule // pmc_top

//--- pmc_sva.sv
// Port checker for the protection checker
`timescale 1ns/1ns
`include "pmc_map.vh"
module pmc_sva (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [31:0] reg_rdata_r,
  input wire logic        chk_valid,
  input wire logic [1:0]  chk_type,
  input wire logic [1:0]  chk_priv,
  input wire logic        chk_ptw,
  input wire logic        res_valid_r,
  input wire logic        res_fail_r,
  input wire logic        exc_fetch_r,
  input wire logic        exc_load_r,
  input wire logic        exc_store_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Conservative: any write to a configuration byte counts
  logic cfg_hit_r;
  always_ff @(posedge clk) begin
    cfg_hit_r <= rstn & (cfg_hit_r | (reg_we & ~reg_addr[7] & ~reg_addr[6]));
  end
  chk_answer_next: assert property (
    chk_valid |=> res_valid_r)
    else $error("no result one cycle after a request");
  chk_answer_cause: assert property (
    res_valid_r |-> $past(chk_valid))
    else $error("result without a request");
  chk_fail_valid: assert property (res_fail_r |-> res_valid_r)
    else $error("fail outside a result cycle");
  chk_exc_fetch: assert property (
    chk_valid && chk_type == `PMC_T_FETCH |=> exc_fetch_r == res_fail_r)
    else $error("fetch exception wrong");
  chk_exc_load: assert property (
    chk_valid && chk_type == `PMC_T_LOAD |=> exc_load_r == res_fail_r)
    else $error("load exception wrong");
  chk_exc_store: assert property (
    chk_valid && chk_type == `PMC_T_STORE |=> exc_store_r == res_fail_r)
    else $error("store exception wrong");
  chk_exc_single: assert property (
    $onehot0({exc_fetch_r, exc_load_r, exc_store_r}))
    else $error("more than one exception");
  chk_no_entry: assert property (
    chk_valid && !cfg_hit_r |=> res_fail_r ==
    ($past(chk_priv) != `PMC_P_MACHINE || $past(chk_ptw)))
    else $error("unmatched access result wrong");
  chk_rdata_idle: assert property (
    !reg_re |=> reg_rdata_r == 32'h0)
    else $error("read data outside read cycle");
  chk_cfg_upper: assert property (reg_re && reg_addr < 8'h40
    |=> reg_rdata_r[31:8] == 24'h0) else $error("config upper bits set");
endmodule // pmc_sva

bind pmc_top pmc_sva u_pmc_sva (.clk, .rstn, .reg_addr, .reg_we, .reg_re,
  .reg_rdata_r, .chk_valid, .chk_type, .chk_priv, .chk_ptw, .res_valid_r,
  .res_fail_r, .exc_fetch_r, .exc_load_r, .exc_store_r);

//--- pmc_hart.sv
// Hart pipeline model issuing protection checks
`timescale 1ns/1ns
module pmc_hart (
  input  wire logic        clk,
  output logic             chk_valid,
  output logic [33:0]      chk_addr,
  output logic [1:0]       chk_size,
  output logic [1:0]       chk_type,
  output logic [1:0]       chk_priv,
  output logic             chk_ptw,
  input  wire logic        res_valid_r,
  input  wire logic        res_fail_r,
  input  wire logic        exc_fetch_r,
  input  wire logic        exc_load_r,
  input  wire logic        exc_store_r
);
  initial begin
    {chk_valid, chk_size, chk_type, chk_priv, chk_ptw} = 8'h00;
    chk_addr = 34'h0;
  end
  task automatic access(input logic [33:0] a, input logic [1:0] sz, t, p,
                        input logic w, output logic [4:0] r);
    int n;
    @(posedge clk);
    chk_valid <= 1'b1;
    chk_addr  <= a;
    chk_size  <= sz;
    chk_type  <= t;
    chk_priv  <= p;
    chk_ptw   <= w;
    @(posedge clk);
    chk_valid <= 1'b0;
    // Idle lines never keep the last address
    chk_addr  <= ~a;
    n = 0;
    #1;
    while (!res_valid_r && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    r = {res_valid_r, res_fail_r, exc_fetch_r, exc_load_r, exc_store_r};
  endtask
endmodule // pmc_hart

//--- pmc_top_tb.sv
// Self-checking bench for the protection checker
`timescale 1ns/1ns
`include "pmc_map.vh"
module pmc_top_tb;
  logic        clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [31:0] reg_rdata_r;
  logic        chk_valid;
  logic [33:0] chk_addr;
  logic [1:0]  chk_size;
  logic [1:0]  chk_type;
  logic [1:0]  chk_priv;
  logic        chk_ptw;
  logic        res_valid_r;
  logic        res_fail_r;
  logic        exc_fetch_r;
  logic        exc_load_r;
  logic        exc_store_r;
  int          mismatches;
  int          samples_checked;
  localparam logic [1:0] F = `PMC_T_FETCH, L = `PMC_T_LOAD, S = `PMC_T_STORE;
  localparam logic [1:0] U = `PMC_P_USER, SV = `PMC_P_SUPER;
  localparam logic [1:0] M = `PMC_P_MACHINE;

  pmc_top u_pmc_top (.clk, .rstn, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata_r, .chk_valid, .chk_addr, .chk_size, .chk_type, .chk_priv,
    .chk_ptw, .res_valid_r, .res_fail_r, .exc_fetch_r, .exc_load_r,
    .exc_store_r);
  pmc_hart u_pmc_hart (.clk, .chk_valid, .chk_addr, .chk_size, .chk_type,
    .chk_priv, .chk_ptw, .res_valid_r, .res_fail_r, .exc_fetch_r,
    .exc_load_r, .exc_store_r);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************************************
  // Common tasks
  // ****************************************************************
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp32(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_res(input string nm, input logic [4:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1 cmp32($sformatf("reg %h", a), e, reg_rdata_r);
  endtask
  // Expected {fail, fetch, load, store}
  task automatic acc(input logic [33:0] a, input logic [1:0] sz, t, p,
                     input logic w, input logic [3:0] e);
    logic [4:0] r;
    u_pmc_hart.access(a, sz, t, p, w, r);
    cmp_res($sformatf("check %h", a), {1'b1, e}, r);
    if (!r[4]) complete_run();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_reset_view;
    rd(8'h00, 32'h0);
    rd(8'h80, 32'h10);
    rd(8'hFC, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'hFFFFFFFF);
  endtask
  task automatic s_no_entry;
    acc(34'h200, 2'h2, L, M, 1'b0, 4'h0);
    acc(34'h200, 2'h2, L, U, 1'b0, 4'hA);
    acc(34'h200, 2'h2, F, SV, 1'b0, 4'hC);
    acc(34'h200, 2'h2, S, M, 1'b1, 4'h9);
  endtask
  task automatic s_tor;
    wr(8'h40, 32'h40);
    wr(8'h00, 32'h09);
    wr(8'h44, 32'h80);
    wr(8'h04, 32'h0B);
    acc(34'hFC, 2'h2, L, U, 1'b0, 4'h0);
    acc(34'h100, 2'h2, S, U, 1'b0, 4'h0);
    acc(34'h0, 2'h2, S, U, 1'b0, 4'h9);
    acc(34'h0, 2'h2, S, M, 1'b0, 4'h0);
    acc(34'h1FC, 2'h2, F, SV, 1'b0, 4'hC);
    acc(34'hFE, 2'h2, L, U, 1'b0, 4'hA);
  endtask
  task automatic s_regions;
    wr(8'h48, 32'h401);
    wr(8'h08, 32'h1C);
    acc(34'h100C, 2'h2, F, U, 1'b0, 4'h0);
    acc(34'h1010, 2'h2, F, U, 1'b0, 4'hC);
    acc(34'h100C, 2'h3, F, U, 1'b0, 4'hC);
    wr(8'h4C, 32'h803);
    wr(8'h0C, 32'h13);
    acc(34'h200C, 2'h2, S, U, 1'b0, 4'h0);
    acc(34'h2008, 2'h3, L, M, 1'b0, 4'hA);
    wr(8'h50, 32'hC00);
    wr(8'h10, 32'h19);
    acc(34'h3004, 2'h2, L, U, 1'b0, 4'h0);
    acc(34'h3008, 2'h2, L, U, 1'b0, 4'hA);
  endtask
  task automatic s_lock;
    wr(8'h54, 32'hD00);
    wr(8'h14, 32'h89);
    wr(8'h50, 32'h0);
    rd(8'h50, 32'hC00);
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h89);
    wr(8'h54, 32'h0);
    rd(8'h54, 32'hD00);
    acc(34'h3100, 2'h2, S, M, 1'b0, 4'h9);
    acc(34'h3100, 2'h2, L, M, 1'b0, 4'h0);
    rd(8'h80, 32'h000B0005);
    wr(8'h80, 32'h0);
    rd(8'h80, 32'h00000005);
    wr(8'h18, 32'hFFFFFF02);
    rd(8'h18, 32'h0);
  endtask
  task automatic s_rereset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h14, 32'h0);
    acc(34'h3100, 2'h2, S, M, 1'b0, 4'h0);
  endtask

  initial begin
    rstn      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
    mismatches      = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    s_reset_view();
    s_no_entry();
    s_tor();
    s_regions();
    s_lock();
    s_rereset();
    complete_run();
  end
endmodule // pmc_top_tb
